// File: logic/agcs_top.v
// AGC gain loop, carrier-sense configuration and register port.
`timescale 1ns/1ps
`default_nettype none
`include "agcs_defs.vh"

module agcs_top #(
  parameter STAGE_MAX = 3'd7,
  parameter STEP_DB = 10'd3
) (
  input wire CLK,
  input wire RESET,
  input wire [`AGCS_ADDR_W-1:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WE,
  input wire REG_RE,
  output reg [7:0] REG_RDATA,
  input wire SAMPLE_STB,
  input wire [7:0] SAMPLE_AMP,
  output reg [2:0] LNA1_GAIN_RED,
  output reg [2:0] LNA2_GAIN_RED,
  output reg GAIN_WAITING,
  output wire CARRIER_SENSE
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function [9:0] target_db;
    input [2:0] code;
    begin
      case (code)
        3'h0: target_db = 10'd24;
        3'h1: target_db = 10'd27;
        3'h2: target_db = 10'd30;
        3'h3: target_db = 10'd33;
        3'h4: target_db = 10'd36;
        3'h5: target_db = 10'd38;
        3'h6: target_db = 10'd40;
        default: target_db = 10'd42;
      endcase
    end
  endfunction

  function [9:0] hyst_up;
    input [1:0] code;
    begin
      case (code)
        2'h0: hyst_up = `AGCS_HYST_UP_00;
        2'h1: hyst_up = `AGCS_HYST_UP_01;
        2'h2: hyst_up = `AGCS_HYST_UP_10;
        default: hyst_up = `AGCS_HYST_UP_11;
      endcase
    end
  endfunction

  function [9:0] hyst_dn;
    input [1:0] code;
    begin
      case (code)
        2'h0: hyst_dn = `AGCS_HYST_DN_00;
        2'h1: hyst_dn = `AGCS_HYST_DN_01;
        2'h2: hyst_dn = `AGCS_HYST_DN_10;
        default: hyst_dn = `AGCS_HYST_DN_11;
      endcase
    end
  endfunction

  // Saturation is checked by the caller; these only step the code.
  function [2:0] inc_red;
    input [2:0] red;
    begin
      inc_red = red + 3'd1;
    end
  endfunction

  function [2:0] dec_red;
    input [2:0] red;
    begin
      dec_red = red - 3'd1;
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  reg [7:0] tgt_reg_q;
  reg [6:0] cs_cfg_q;
  reg [7:0] loop_q;
  localparam [7:0] CS_CFG_RST = `AGCS_CS_CFG_RST;

  wire prio;
  wire [1:0] rel_code;
  wire [3:0] abs_code;
  wire [2:0] tgt_code;
  wire [1:0] hyst_code;
  wire [1:0] wait_code;

  assign prio = cs_cfg_q[`AGCS_PRIO_BIT];
  assign rel_code = cs_cfg_q[`AGCS_REL_HI:`AGCS_REL_LO];
  assign abs_code = cs_cfg_q[`AGCS_ABS_HI:`AGCS_ABS_LO];
  assign tgt_code = tgt_reg_q[`AGCS_TGT_HI:`AGCS_TGT_LO];
  assign hyst_code = loop_q[`AGCS_HYST_HI:`AGCS_HYST_LO];
  assign wait_code = loop_q[`AGCS_WAIT_HI:`AGCS_WAIT_LO];

  always @(posedge CLK) begin
    if (RESET) begin
      tgt_reg_q <= `AGCS_TARGET_RST;
      cs_cfg_q <= CS_CFG_RST[6:0];
      loop_q <= `AGCS_LOOP_RST;
    end else if (REG_WE) begin
      case (REG_ADDR)
        `AGCS_TARGET_ADDR: begin
          tgt_reg_q <= REG_WDATA;
        end
        `AGCS_CS_CFG_ADDR: begin
          cs_cfg_q <= REG_WDATA[6:0];
        end
        `AGCS_LOOP_ADDR: begin
          loop_q <= REG_WDATA;
        end
        default: begin
          loop_q <= loop_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  reg [7:0] rd_d;
  wire [7:0] status_word;

  // Status byte: carrier, settling flag, then both stage reductions.
  assign status_word = {CARRIER_SENSE, GAIN_WAITING, LNA1_GAIN_RED, LNA2_GAIN_RED};

  always @* begin
    case (REG_ADDR)
      `AGCS_TARGET_ADDR: rd_d = tgt_reg_q;
      `AGCS_CS_CFG_ADDR: rd_d = {1'b0, cs_cfg_q};
      `AGCS_LOOP_ADDR: rd_d = loop_q;
      `AGCS_STATUS_ADDR: rd_d = status_word;
      default: rd_d = 8'h00;
    endcase
  end

  always @(posedge CLK) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RE) begin
      REG_RDATA <= rd_d;
    end
  end

  // ----------------------------------------------------------------
  // Gain loop
  // ----------------------------------------------------------------
  localparam ST_TRACK = 1'b0;
  localparam ST_WAIT = 1'b1;

  reg state_q;
  reg [5:0] wait_cnt_q;
  reg [2:0] lna1_d;
  reg [2:0] lna2_d;
  reg lower_req;
  reg raise_req;
  reg state_d;
  reg [5:0] wait_cnt_d;
  reg waiting_d;

  wire [9:0] tgt_db;
  wire [9:0] amp;
  wire [9:0] red_db;
  wire [9:0] strength;
  wire [5:0] wait_len;
  wire gain_move;

  assign tgt_db = target_db(tgt_code);
  assign amp = {2'b00, SAMPLE_AMP};
  assign red_db = ({7'd0, LNA1_GAIN_RED} + {7'd0, LNA2_GAIN_RED}) * STEP_DB;
  assign strength = amp + red_db;
  assign wait_len = {4'd0, wait_code} * `AGCS_WAIT_STEP + `AGCS_WAIT_STEP;
  // A step is wanted whenever either stage would take a new code.
  assign gain_move = (lna1_d != LNA1_GAIN_RED) || (lna2_d != LNA2_GAIN_RED);

  // Dead zone: above target plus upper margin lowers gain, below minus lower raises.
  always @* begin
    lower_req = (amp > tgt_db + hyst_up(hyst_code));
    raise_req = (amp + hyst_dn(hyst_code) < tgt_db);
  end

  always @* begin
    lna1_d = LNA1_GAIN_RED;
    lna2_d = LNA2_GAIN_RED;
    if (lower_req) begin
      if (prio) begin
        if (LNA1_GAIN_RED != STAGE_MAX) begin
          lna1_d = inc_red(LNA1_GAIN_RED);
        end else if (LNA2_GAIN_RED != STAGE_MAX) begin
          lna2_d = inc_red(LNA2_GAIN_RED);
        end
      end else begin
        if (LNA2_GAIN_RED != STAGE_MAX) begin
          lna2_d = inc_red(LNA2_GAIN_RED);
        end else if (LNA1_GAIN_RED != STAGE_MAX) begin
          lna1_d = inc_red(LNA1_GAIN_RED);
        end
      end
    end else if (raise_req) begin
      // Gain comes back in the reverse order of its removal.
      if (prio) begin
        if (LNA2_GAIN_RED != 3'd0) begin
          lna2_d = dec_red(LNA2_GAIN_RED);
        end else if (LNA1_GAIN_RED != 3'd0) begin
          lna1_d = dec_red(LNA1_GAIN_RED);
        end
      end else begin
        if (LNA1_GAIN_RED != 3'd0) begin
          lna1_d = dec_red(LNA1_GAIN_RED);
        end else if (LNA2_GAIN_RED != 3'd0) begin
          lna2_d = dec_red(LNA2_GAIN_RED);
        end
      end
    end
  end

  // Settling wait: a gain step arms the counter, each later sample counts it down.
  always @* begin
    state_d = state_q;
    wait_cnt_d = wait_cnt_q;
    waiting_d = GAIN_WAITING;
    case (state_q)
      ST_TRACK: begin
        if (gain_move) begin
          wait_cnt_d = wait_len;
          state_d = ST_WAIT;
          waiting_d = 1'b1;
        end
      end
      ST_WAIT: begin
        if (wait_cnt_q == 6'd1) begin
          state_d = ST_TRACK;
          waiting_d = 1'b0;
        end
        wait_cnt_d = wait_cnt_q - 6'd1;
      end
      default: begin
        state_d = ST_TRACK;
        waiting_d = 1'b0;
      end
    endcase
  end

  // Gains and the wait state move only on a sample strobe.
  always @(posedge CLK) begin
    if (RESET) begin
      state_q <= ST_TRACK;
      wait_cnt_q <= 6'd0;
      LNA1_GAIN_RED <= 3'd0;
      LNA2_GAIN_RED <= 3'd0;
      GAIN_WAITING <= 1'b0;
    end else if (SAMPLE_STB) begin
      state_q <= state_d;
      wait_cnt_q <= wait_cnt_d;
      GAIN_WAITING <= waiting_d;
      if (state_q == ST_TRACK) begin
        LNA1_GAIN_RED <= lna1_d;
        LNA2_GAIN_RED <= lna2_d;
      end
    end
  end

  // ----------------------------------------------------------------
  // Carrier sense
  // ----------------------------------------------------------------
  agcs_cs_detect u_cs (
    .clk(CLK),
    .reset(RESET),
    .sample_stb(SAMPLE_STB),
    .strength(strength),
    .target_db(tgt_db),
    .abs_code(abs_code),
    .rel_code(rel_code),
    .carrier_q(CARRIER_SENSE)
  );

endmodule
`default_nettype wire

// File: logic/agcs_defs.vh
// Register map, field layout, reset values and decode tables for the AGC and carrier-sense block.
`ifndef AGCS_DEFS_VH
`define AGCS_DEFS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define AGCS_ADDR_W 6
`define AGCS_TARGET_ADDR 6'h1b
`define AGCS_CS_CFG_ADDR 6'h1c
`define AGCS_LOOP_ADDR 6'h1d
`define AGCS_STATUS_ADDR 6'h34

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AGCS_TARGET_RST 8'h03
`define AGCS_CS_CFG_RST 8'h40
`define AGCS_LOOP_RST 8'h91

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define AGCS_CS_UNUSED_BIT 7
`define AGCS_PRIO_BIT 6
`define AGCS_REL_HI 5
`define AGCS_REL_LO 4
`define AGCS_ABS_HI 3
`define AGCS_ABS_LO 0
`define AGCS_TGT_HI 2
`define AGCS_TGT_LO 0
`define AGCS_HYST_HI 7
`define AGCS_HYST_LO 6
`define AGCS_WAIT_HI 5
`define AGCS_WAIT_LO 4

// ----------------------------------------------------------------
// Codes and decode values
// ----------------------------------------------------------------
`define AGCS_ABS_DISABLE 4'h8
`define AGCS_REL_DISABLE 2'h0
`define AGCS_REL_RISE_01 10'd6
`define AGCS_REL_RISE_10 10'd10
`define AGCS_REL_RISE_11 10'd14
`define AGCS_WAIT_STEP 6'd8
`define AGCS_HYST_UP_00 10'd1
`define AGCS_HYST_UP_01 10'd2
`define AGCS_HYST_UP_10 10'd4
`define AGCS_HYST_UP_11 10'd6
`define AGCS_HYST_DN_00 10'd1
`define AGCS_HYST_DN_01 10'd1
`define AGCS_HYST_DN_10 10'd2
`define AGCS_HYST_DN_11 10'd3

`endif

// File: logic/agcs_cs_detect.v
// Carrier-sense decision from input-referred signal strength.
`timescale 1ns/1ps
`default_nettype none
`include "agcs_defs.vh"

module agcs_cs_detect (
  input wire clk,
  input wire reset,
  input wire sample_stb,
  input wire [9:0] strength,
  input wire [9:0] target_db,
  input wire [3:0] abs_code,
  input wire [1:0] rel_code,
  output reg carrier_q
);

  // ----------------------------------------------------------------
  // Threshold decode
  // ----------------------------------------------------------------
  function [9:0] rel_rise;
    input [1:0] code;
    begin
      case (code)
        2'h1: rel_rise = `AGCS_REL_RISE_01;
        2'h2: rel_rise = `AGCS_REL_RISE_10;
        default: rel_rise = `AGCS_REL_RISE_11;
      endcase
    end
  endfunction

  reg [9:0] base_q;
  wire [9:0] abs_thr;
  wire [10:0] rel_thr;
  wire abs_hit;
  wire rel_hit;

  // Target plus sign-extended offset; always positive for legal targets.
  assign abs_thr = target_db + {{6{abs_code[3]}}, abs_code};
  assign abs_hit = (abs_code != `AGCS_ABS_DISABLE) && (strength >= abs_thr);
  assign rel_thr = {1'b0, base_q} + {1'b0, rel_rise(rel_code)};
  assign rel_hit = (rel_code != `AGCS_REL_DISABLE) && ({1'b0, strength} >= rel_thr);

  // ----------------------------------------------------------------
  // Baseline tracking and decision
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      base_q <= 10'h3ff;
      carrier_q <= 1'b0;
    end else if (sample_stb) begin
      // Baseline follows drops at once and creeps up 1 dB per sample.
      if (strength < base_q) begin
        base_q <= strength;
      end else if (strength > base_q) begin
        base_q <= base_q + 10'd1;
      end
      carrier_q <= abs_hit | rel_hit;
    end
  end

endmodule
`default_nettype wire

// File: test/agcs_checker.sv
// Port checker for the AGC and carrier-sense block.
`timescale 1ns/1ps
`default_nettype none
`include "agcs_defs.vh"
module agcs_checker #(
  parameter STAGE_MAX = 3'd7,
  parameter STEP_DB = 10'd3
) (
  input wire CLK,
  input wire RESET,
  input wire [`AGCS_ADDR_W-1:0] REG_ADDR,
  input wire [7:0] REG_WDATA,
  input wire REG_WE,
  input wire REG_RE,
  input wire [7:0] REG_RDATA,
  input wire SAMPLE_STB,
  input wire [7:0] SAMPLE_AMP,
  input wire [2:0] LNA1_GAIN_RED,
  input wire [2:0] LNA2_GAIN_RED,
  input wire GAIN_WAITING,
  input wire CARRIER_SENSE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  sequence s_lna1_up;
    LNA1_GAIN_RED > $past(LNA1_GAIN_RED);
  endsequence
  sequence s_lna2_up;
    LNA2_GAIN_RED > $past(LNA2_GAIN_RED);
  endsequence
  sequence s_change;
    !$stable(LNA1_GAIN_RED) || !$stable(LNA2_GAIN_RED);
  endsequence
  a_first_stage_order: assert property (s_lna1_up |->
    $past(LNA2_GAIN_RED) == 3'h0 || $past(LNA2_GAIN_RED) == STAGE_MAX) else $error("lna1 order");
  a_second_stage_order: assert property (s_lna2_up |->
    $past(LNA1_GAIN_RED) == 3'h0 || $past(LNA1_GAIN_RED) == STAGE_MAX) else $error("lna2 order");
  a_change_sets_wait: assert property (s_change |-> GAIN_WAITING)
    else $error("no wait after gain change");
  a_wait_blocks_gain: assert property ($past(GAIN_WAITING) |->
    $stable(LNA1_GAIN_RED) && $stable(LNA2_GAIN_RED)) else $error("gain changed in wait");
  a_wait_min_len: assert property ($rose(GAIN_WAITING) |-> GAIN_WAITING [*8])
    else $error("wait too short");
  a_cs_on_strobe: assert property (!$past(SAMPLE_STB) |-> $stable(CARRIER_SENSE))
    else $error("carrier changed without sample");
  a_unused_bit_zero: assert property (REG_RE && REG_ADDR == `AGCS_CS_CFG_ADDR |=>
    !REG_RDATA[7]) else $error("unused bit set");
  a_status_read: assert property (REG_RE && REG_ADDR == `AGCS_STATUS_ADDR |=> REG_RDATA ==
    {$past(CARRIER_SENSE), $past(GAIN_WAITING), $past(LNA1_GAIN_RED), $past(LNA2_GAIN_RED)})
    else $error("status mismatch");
  a_rdata_holds: assert property (!$past(REG_RE) |-> $stable(REG_RDATA))
    else $error("read data moved");
endmodule
bind agcs_top agcs_checker #(.STAGE_MAX(STAGE_MAX), .STEP_DB(STEP_DB)) chk_u (.CLK(CLK),
  .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE),
  .REG_RE(REG_RE), .REG_RDATA(REG_RDATA), .SAMPLE_STB(SAMPLE_STB), .SAMPLE_AMP(SAMPLE_AMP),
  .LNA1_GAIN_RED(LNA1_GAIN_RED), .LNA2_GAIN_RED(LNA2_GAIN_RED),
  .GAIN_WAITING(GAIN_WAITING), .CARRIER_SENSE(CARRIER_SENSE));
`default_nettype wire

// File: test/agcs_top_tb_top.sv
// Self-checking testbench for the AGC and carrier-sense block.
`timescale 1ns/1ps
`default_nettype none
`include "agcs_defs.vh"
module agcs_top_tb_top;
  logic CLK = 0, RESET = 1, REG_WE = 0, REG_RE = 0, SAMPLE_STB = 0;
  logic [5:0] REG_ADDR = 6'h00;
  logic [7:0] REG_WDATA = 8'h00, SAMPLE_AMP = 8'h00, REG_RDATA, rise;
  logic [2:0] LNA1_GAIN_RED, LNA2_GAIN_RED;
  logic GAIN_WAITING, CARRIER_SENSE;
  int failures = 0, cmp_count = 0, n, i;
  agcs_top dut_u (.CLK(CLK), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA), .SAMPLE_STB(SAMPLE_STB),
    .SAMPLE_AMP(SAMPLE_AMP), .LNA1_GAIN_RED(LNA1_GAIN_RED), .LNA2_GAIN_RED(LNA2_GAIN_RED),
    .GAIN_WAITING(GAIN_WAITING), .CARRIER_SENSE(CARRIER_SENSE));
  initial begin
    forever #2.5 CLK = ~CLK;
  end
  task automatic stop_test;
    $display("failures=%0d cmp_count=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic rst;
    RESET <= 1;
    repeat (16) @(posedge CLK);
    RESET <= 0;
    @(posedge CLK);
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WE <= 1;
    @(posedge CLK);
    REG_WE <= 0;
    @(posedge CLK);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    REG_ADDR <= a;
    REG_RE <= 1;
    @(posedge CLK);
    REG_RE <= 0;
    @(posedge CLK);
    chk(REG_RDATA, e);
  endtask
  task automatic smp(input logic [7:0] amp);
    SAMPLE_AMP <= amp;
    SAMPLE_STB <= 1;
    @(posedge CLK);
    SAMPLE_STB <= 0;
    @(posedge CLK);
  endtask
  task automatic cs(input logic [7:0] cfg, input logic [7:0] amp, input logic [7:0] e);
    wr(`AGCS_CS_CFG_ADDR, cfg);
    smp(amp);
    chk({7'h00, CARRIER_SENSE}, e);
  endtask
  task automatic gs(input logic [7:0] e);
    chk({1'h0, GAIN_WAITING, LNA1_GAIN_RED, LNA2_GAIN_RED}, e);
  endtask
  initial begin
    #100000;
    failures++;
    stop_test;
  end
  initial begin
    @(posedge CLK);
    rst;
    rd(`AGCS_TARGET_ADDR, 8'h03);
    rd(`AGCS_CS_CFG_ADDR, 8'h40);
    rd(`AGCS_LOOP_ADDR, 8'h91);
    rd(6'h00, 8'h00);
    wr(`AGCS_CS_CFG_ADDR, 8'hff);
    rd(`AGCS_CS_CFG_ADDR, 8'h7f);
    wr(`AGCS_STATUS_ADDR, 8'hff);
    rd(`AGCS_STATUS_ADDR, 8'h00);
    wr(`AGCS_TARGET_ADDR, 8'h07);
    rd(`AGCS_TARGET_ADDR, 8'h07);
    cs(8'h40, 8'h29, 8'h00);
    cs(8'h40, 8'h2a, 8'h01);
    wr(`AGCS_TARGET_ADDR, 8'h03);
    cs(8'h40, 8'h20, 8'h00);
    cs(8'h40, 8'h21, 8'h01);
    cs(8'h4f, 8'h1f, 8'h00);
    cs(8'h4f, 8'h20, 8'h01);
    cs(8'h47, 8'h25, 8'h00);
    cs(8'h49, 8'h1a, 8'h01);
    cs(8'h49, 8'h19, 8'h00);
    cs(8'h48, 8'h25, 8'h00);
    for (i = 1; i < 4; i++) begin
      rise = {i[5:0], 2'h2};
      cs({2'h1, i[1:0], 4'h8}, 8'h14, 8'h00);
      cs({2'h1, i[1:0], 4'h8}, 8'h14, 8'h00);
      cs({2'h1, i[1:0], 4'h8}, 8'h13 + rise, 8'h00);
      cs({2'h1, i[1:0], 4'h8}, 8'h14, 8'h00);
      cs({2'h1, i[1:0], 4'h8}, 8'h14 + rise, 8'h01);
    end
    cs(8'h57, 8'h14, 8'h00);
    cs(8'h57, 8'h1a, 8'h01);
    cs(8'h57, 8'h14, 8'h00);
    wr(`AGCS_CS_CFG_ADDR, 8'h40);
    smp(8'h25);
    gs(8'h00);
    smp(8'h26);
    gs(8'h48);
    n = 0;
    while (GAIN_WAITING === 1'b1 && n < 40) begin
      smp(8'h26);
      n++;
    end
    chk(n[7:0], 8'h10);
    gs(8'h08);
    cs(8'h40, 8'h1f, 8'h01);
    wr(`AGCS_LOOP_ADDR, 8'h01);
    smp(8'h23);
    gs(8'h50);
    rst;
    wr(`AGCS_CS_CFG_ADDR, 8'h00);
    wr(`AGCS_LOOP_ADDR, 8'h81);
    smp(8'h3c);
    gs(8'h41);
    repeat (63) smp(8'h3c);
    gs(8'h4f);
    rd(`AGCS_STATUS_ADDR, 8'hcf);
    stop_test;
  end
endmodule
`default_nettype wire
